// *** design/line_modes_pkg.sv ***
// package for the serial line-mode block: register map, fields, reset values
package line_modes_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CONTROL_REG_OFF      = 8'h00;
  localparam logic [7:0] MODE_REG_OFF         = 8'h04;
  localparam logic [7:0] CHANNEL_STATUS_OFF   = 8'h14;
  localparam logic [7:0] TIMEGUARD_REG_OFF    = 8'h28;
  localparam logic [7:0] CARD_CLOCK_RATIO_OFF = 8'h40;
  localparam logic [7:0] IR_FILTER_REG_OFF    = 8'h4C;
  localparam logic [7:0] BAUD_DIVISOR_OFF     = 8'h20;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int OP_MODE_LSB        = 0;   // 4-bit operating mode
  localparam int CHAN_MODE_LSB      = 14;  // 2-bit channel test mode
  localparam int TERM_READY_ON_BIT  = 16;
  localparam int TERM_READY_OFF_BIT = 17;
  localparam int RING_CHG_BIT       = 16;
  localparam int SET_READY_CHG_BIT  = 17;
  localparam int CARRIER_CHG_BIT    = 18;
  localparam int CTS_CHG_BIT        = 19;
  localparam int RING_LVL_BIT       = 20;
  localparam int SET_READY_LVL_BIT  = 21;
  localparam int CARRIER_LVL_BIT    = 22;
  localparam int CTS_LVL_BIT        = 23;
  localparam int TX_EMPTY_BIT       = 9;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] MODE_RST        = 32'h0000_0000;
  localparam logic [15:0] CLOCK_RATIO_RST = 16'h0174;
  localparam logic [7:0]  IR_FILTER_RST   = 8'h00;
  localparam logic [15:0] DIVISOR_RST     = 16'h0000;
  localparam logic [7:0]  TIMEGUARD_RST   = 8'h00;

  // ---------------------------------------------------------------
  // encodings and constants
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_NORMAL = 4'h0;
  localparam logic [3:0] OP_RS485  = 4'h1;
  localparam logic [3:0] OP_MODEM  = 4'h3;
  localparam logic [3:0] OP_IRDA   = 4'h8;
  localparam logic [1:0] CH_NORMAL = 2'h0;
  localparam logic [1:0] CH_ECHO   = 2'h1;
  localparam logic [1:0] CH_LOCAL  = 2'h2;
  localparam logic [1:0] CH_REMOTE = 2'h3;
  localparam int SAMPLES_PER_BIT   = 16;
  localparam int PULSE_SAMPLES     = 3;    // 3/16 of a bit

  // modem inputs carried together
  typedef struct packed {
    logic ring;
    logic set_ready;
    logic carrier;
    logic clear_to_send;
  } modem_in_t;

  typedef enum logic [2:0] {
    DM_IDLE  = 3'b001,
    DM_COUNT = 3'b010,
    DM_LOW   = 3'b100
  } demod_state_t;

endpackage : line_modes_pkg

// *** design/line_modes.sv ***
// line-mode logic: infrared codec, rs485 driver enable, modem control, test loops
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module line_modes
  import line_modes_pkg::*;
(
  input  wire logic        pclk,          // master clock, 20 MHz
  input  wire logic        presetn,       // async reset, active low
  input  wire logic        psel,          // apb select
  input  wire logic        penable,       // apb access phase
  input  wire logic        pwrite,        // apb direction
  input  wire logic [7:0]  paddr,         // apb byte address
  input  wire logic [31:0] pwdata,        // apb write data
  output logic      [31:0] prdata,        // apb read data
  output logic             pready,        // apb ready
  output logic             pslverr,       // apb error, unmapped
  input  wire logic        core_txd,      // transmitter serial output
  input  wire logic        tx_empty,      // transmitter empty flag
  input  wire logic        tx_busy_char,  // character in progress
  input  wire logic        timeguard_run, // timeguard counting
  output logic             core_rxd,      // receiver serial input
  output logic             tx_allow,      // transmitter may start
  output logic             rx_enable_ok,  // receiver usable
  input  wire logic        rxd_pin,       // receive pin
  output logic             txd_pin,       // transmit pin
  output logic             rts_n_pin,     // request to send, active low
  output logic             dtr_n_pin,     // terminal ready, active low
  input  wire modem_in_t   modem_n_pin    // modem inputs, active low
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [31:0]  mode_ff;
  logic [15:0]  ratio_ff;
  logic [7:0]   filter_ff;
  logic [15:0]  divisor_ff;
  logic [7:0]   guard_ff;
  logic         dtr_n_ff;
  logic [3:0]   chg_ff;
  logic [3:0]   nxt_chg;
  logic [1:0]   rx_sync_ff;
  logic [3:0]   m_sync0_ff, m_sync1_ff, m_last_ff;
  logic [3:0]   op_mode;
  logic [1:0]   ch_mode;
  logic         wr_en, rd_en, rd_status, mapped;
  logic         irda, rx_line;

  assign op_mode   = mode_ff[OP_MODE_LSB +: 4];
  assign ch_mode   = mode_ff[CHAN_MODE_LSB +: 2];
  assign irda      = (op_mode == OP_IRDA);
  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && penable && !pwrite;
  assign rd_status = rd_en && (paddr == CHANNEL_STATUS_OFF);
  assign pready    = 1'b1;

  // address decode
  always_comb begin
    case (paddr)
      CONTROL_REG_OFF, MODE_REG_OFF, CHANNEL_STATUS_OFF, TIMEGUARD_REG_OFF,
      CARD_CLOCK_RATIO_OFF, IR_FILTER_REG_OFF, BAUD_DIVISOR_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff    <= MODE_RST;
      ratio_ff   <= CLOCK_RATIO_RST;
      filter_ff  <= IR_FILTER_RST;
      divisor_ff <= DIVISOR_RST;
      guard_ff   <= TIMEGUARD_RST;
    end else if (wr_en) begin
      case (paddr)
        MODE_REG_OFF:         mode_ff    <= pwdata;
        CARD_CLOCK_RATIO_OFF: ratio_ff   <= pwdata[15:0];   // stored and read back only, unused by the irda logic
        IR_FILTER_REG_OFF:    filter_ff  <= pwdata[7:0];
        BAUD_DIVISOR_OFF:     divisor_ff <= pwdata[15:0];
        TIMEGUARD_REG_OFF:    guard_ff   <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // terminal-ready pin from control commands, off wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dtr_n_ff <= 1'b1;
    end else if (wr_en && paddr == CONTROL_REG_OFF) begin
      if (pwdata[TERM_READY_OFF_BIT]) begin
        dtr_n_ff <= 1'b1;
      end else if (pwdata[TERM_READY_ON_BIT]) begin
        dtr_n_ff <= 1'b0;
      end
    end
  end
  assign dtr_n_pin = dtr_n_ff;

  // ---------------------------------------------------------------
  // modem input sync and change flags
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_sync0_ff <= 4'hF;
      m_sync1_ff <= 4'hF;
      m_last_ff  <= 4'hF;
      rx_sync_ff <= 2'b11;
    end else begin
      m_sync0_ff <= modem_n_pin;
      m_sync1_ff <= m_sync0_ff;
      m_last_ff  <= m_sync1_ff;
      rx_sync_ff <= {rx_sync_ff[0], rxd_pin};
    end
  end
  assign rx_line = rx_sync_ff[1];

  // set wins over the read clear
  always_comb begin
    nxt_chg = rd_status ? 4'h0 : chg_ff;
    if (op_mode == OP_MODEM) begin
      nxt_chg = nxt_chg | (m_sync1_ff ^ m_last_ff);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_ff <= 4'h0;
    end else begin
      chg_ff <= nxt_chg;
    end
  end

  // read data
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      case (paddr)
        MODE_REG_OFF:         prdata = mode_ff;
        CARD_CLOCK_RATIO_OFF: prdata = {16'h0000, ratio_ff};
        IR_FILTER_REG_OFF:    prdata = {24'h00_0000, filter_ff};
        BAUD_DIVISOR_OFF:     prdata = {16'h0000, divisor_ff};
        TIMEGUARD_REG_OFF:    prdata = {24'h00_0000, guard_ff};
        CHANNEL_STATUS_OFF: begin
          prdata[RING_CHG_BIT]      = chg_ff[3];
          prdata[SET_READY_CHG_BIT] = chg_ff[2];
          prdata[CARRIER_CHG_BIT]   = chg_ff[1];
          prdata[CTS_CHG_BIT]       = chg_ff[0];
          prdata[RING_LVL_BIT]      = m_sync1_ff[3];
          prdata[SET_READY_LVL_BIT] = m_sync1_ff[2];
          prdata[CARRIER_LVL_BIT]   = m_sync1_ff[1];
          prdata[CTS_LVL_BIT]       = m_sync1_ff[0];
          prdata[TX_EMPTY_BIT]      = tx_empty;
        end
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // modulator: pulse on zero bits, 3 of 16 samples
  // ---------------------------------------------------------------
  // sample divider restarts on every bit edge, so the pulse width
  // never depends on where a free-running divider happened to stand
  logic [15:0] mod_div_ff;
  logic [3:0]  samp_ff;
  logic        core_txd_q_ff, ir_tx_ff;
  logic        tx_edge;
  assign tx_edge = (core_txd != core_txd_q_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mod_div_ff    <= DIVISOR_RST;
      samp_ff       <= 4'h0;
      core_txd_q_ff <= 1'b1;
      ir_tx_ff      <= 1'b0;
    end else begin
      core_txd_q_ff <= core_txd;
      if (tx_edge) begin
        mod_div_ff <= divisor_ff;
        samp_ff    <= 4'h0;                                       // bit edge realigns
      end else if (mod_div_ff == 16'h0000) begin
        mod_div_ff <= divisor_ff;
        samp_ff    <= samp_ff + 4'h1;                             // wraps once per bit
      end else begin
        mod_div_ff <= mod_div_ff - 16'h0001;
      end
      ir_tx_ff <= !core_txd && !tx_edge && (samp_ff < 4'(PULSE_SAMPLES));
    end
  end

  // ---------------------------------------------------------------
  // demodulator filter
  // ---------------------------------------------------------------
  demod_state_t dm_ff;
  logic [7:0]   filt_cnt_ff;
  logic [7:0]   low_cnt_ff;
  logic [15:0]  low_div_ff;  // sample divider of the forced low bit
  logic         rx_prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dm_ff       <= DM_IDLE;
      filt_cnt_ff <= 8'h00;
      low_cnt_ff  <= 8'h00;
      low_div_ff  <= DIVISOR_RST;
      rx_prev_ff  <= 1'b1;
    end else begin
      rx_prev_ff <= rx_line;
      case (dm_ff)
        DM_IDLE: begin
          filt_cnt_ff <= filter_ff;
          if (irda && rx_prev_ff && !rx_line) begin
            dm_ff <= DM_COUNT;
          end
        end
        DM_COUNT: begin
          if (!rx_prev_ff && rx_line) begin
            filt_cnt_ff <= filter_ff;
            dm_ff       <= DM_IDLE;
          end else if (filt_cnt_ff == 8'h00) begin
            low_cnt_ff <= 8'h00;
            low_div_ff <= divisor_ff;                             // bit timed from expiry
            dm_ff      <= DM_LOW;
          end else begin
            filt_cnt_ff <= filt_cnt_ff - 8'h01;
          end
        end
        DM_LOW: begin
          if (low_div_ff == 16'h0000) begin
            low_div_ff <= divisor_ff;
            low_cnt_ff <= low_cnt_ff + 8'h01;
            if (low_cnt_ff == 8'(SAMPLES_PER_BIT - 1)) begin
              dm_ff <= DM_IDLE;
            end
          end else begin
            low_div_ff <= low_div_ff - 16'h0001;
          end
        end
        default: dm_ff <= DM_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // channel routing and line control
  // ---------------------------------------------------------------
  logic rx_src, tx_src;
  always_comb begin
    rx_src = irda ? (dm_ff != DM_LOW) : rx_line;
    tx_src = irda ? ir_tx_ff : core_txd;
    case (ch_mode)
      CH_ECHO:   begin core_rxd = rx_src;   txd_pin = rx_line; end
      CH_LOCAL:  begin core_rxd = core_txd; txd_pin = 1'b1;    end
      CH_REMOTE: begin core_rxd = 1'b1;     txd_pin = rx_line; end
      default:   begin core_rxd = rx_src;   txd_pin = tx_src;  end
    endcase
  end
  assign rx_enable_ok = (ch_mode != CH_REMOTE);

  // rts: rs485 pin high enables the line driver while sending or guarding
  always_comb begin
    case (op_mode)
      OP_RS485: rts_n_pin = !tx_empty || timeguard_run;
      OP_MODEM: rts_n_pin = tx_empty;
      default:  rts_n_pin = 1'b1;
    endcase
  end

  // clear-to-send high blocks new characters only
  assign tx_allow = (ch_mode != CH_REMOTE) &&
                    !(op_mode == OP_MODEM && m_sync1_ff[0] && !tx_busy_char);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_chg_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd_status && (m_sync1_ff == m_last_ff) |=> chg_ff == 4'h0)
    else $error("change flags not cleared by read");
  a_chg_set: assert property (@(posedge pclk) disable iff (!presetn)
    op_mode == OP_MODEM && m_sync1_ff[0] != m_last_ff[0] |=> chg_ff[0])
    else $error("change flag not set");
  a_rs485_rts: assert property (@(posedge pclk) disable iff (!presetn)
    op_mode == OP_RS485 && !tx_empty |-> rts_n_pin)
    else $error("rts not driven high in rs485");
  a_rs485_guard: assert property (@(posedge pclk) disable iff (!presetn)
    op_mode == OP_RS485 && timeguard_run |-> rts_n_pin)
    else $error("rts dropped during timeguard");
  a_filter_start: assert property (@(posedge pclk) disable iff (!presetn)
    irda && dm_ff == DM_IDLE && rx_prev_ff && !rx_line |=> dm_ff == DM_COUNT)
    else $error("filter not started on fall");
  a_filter_reload: assert property (@(posedge pclk) disable iff (!presetn)
    dm_ff == DM_COUNT && !rx_prev_ff && rx_line |=> dm_ff == DM_IDLE)
    else $error("filter not stopped on rise");
  a_filter_expire: assert property (@(posedge pclk) disable iff (!presetn)
    dm_ff == DM_COUNT && filt_cnt_ff == 8'h00 && !(rx_line && !rx_prev_ff)
    |=> dm_ff == DM_LOW)
    else $error("filter expiry missed");
  a_demod_exit: assert property (@(posedge pclk) disable iff (!presetn)
    dm_ff == DM_LOW && low_div_ff == 16'h0000 && low_cnt_ff == 8'(SAMPLES_PER_BIT - 1)
    |=> dm_ff == DM_IDLE)
    else $error("forced low bit not ended");
  a_local_idle: assert property (@(posedge pclk) disable iff (!presetn)
    ch_mode == CH_LOCAL |-> txd_pin && core_rxd == core_txd)
    else $error("local loop wrong");
  a_echo_path: assert property (@(posedge pclk) disable iff (!presetn)
    ch_mode == CH_ECHO |-> txd_pin == rx_line)
    else $error("echo path wrong");
  a_remote_loop: assert property (@(posedge pclk) disable iff (!presetn)
    ch_mode == CH_REMOTE |-> txd_pin == rx_line && !tx_allow)
    else $error("remote loop wrong");
  a_cts_finish: assert property (@(posedge pclk) disable iff (!presetn)
    op_mode == OP_MODEM && ch_mode != CH_REMOTE && tx_busy_char |-> tx_allow)
    else $error("character cut by clear-to-send");
  a_dtr_cmd: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == CONTROL_REG_OFF && pwdata[TERM_READY_OFF_BIT] |=> dtr_n_pin)
    else $error("dtr off failed");
  a_ir_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    core_txd_q_ff |=> !ir_tx_ff)
    else $error("pulse on one bit");
  c_ir_filter_pass: cover property (@(posedge pclk) dm_ff == DM_LOW);
  c_flag_read: cover property (@(posedge pclk) rd_status && chg_ff != 4'h0);
  c_rs485_tx: cover property (@(posedge pclk) op_mode == OP_RS485 && rts_n_pin);
  c_ir_light: cover property (@(posedge pclk) ir_tx_ff);

endmodule : line_modes

// *** sim/line_partner.sv ***
// partner model: infrared transceiver or modem on the line side
`timescale 1ns/1ps
module line_partner
  import line_modes_pkg::*;
(
  input  wire logic pclk,        // master clock
  output logic      rxd_pin,     // line level into the block
  output modem_in_t modem_n_pin  // modem signals, active low
);
  // ---------------------------------------------------------------
  // line drivers
  // ---------------------------------------------------------------
  // idle line high, every modem signal active
  initial begin
    rxd_pin     = 1'b1;
    modem_n_pin = '0;
  end

  // new line level just after an edge
  task automatic set_line(input logic v);
    @(posedge pclk);
    rxd_pin <= v;
  endtask : set_line

  // received light pulse, seen as a low of n clocks
  task automatic ir_pulse(input int n);
    set_line(1'b0);
    repeat (n) @(posedge pclk);
    rxd_pin <= 1'b1;
  endtask : ir_pulse

  // new modem signal levels just after an edge
  task automatic set_modem(input modem_in_t v);
    @(posedge pclk);
    modem_n_pin <= v;
  endtask : set_modem
endmodule : line_partner

// *** sim/testbench.sv ***
// self-checking bench for the line-mode block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module testbench;
  import line_modes_pkg::*;
  typedef struct {string nm; int kind; logic [32:0] msk; logic [32:0] exp;} note_t;
  note_t       notes[$];
  note_t       nt;
  logic [32:0] got;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rnd = 32'h4721_e2b8;
  logic        core_txd = 1'b1, tx_empty = 1'b1, tx_busy_char = 1'b0, timeguard_run = 1'b0;
  logic        pready, pslverr, core_rxd, tx_allow, rx_enable_ok, rxd_pin, txd_pin;
  logic        rts_n_pin, dtr_n_pin, probe = 1'b0, clr = 1'b0, txd_idle;
  modem_in_t   modem_n_pin;
  int          errors = 0, n_compared = 0, cycles = 0, rx_lo = 0, tx_act = 0, f, d;

  line_modes line_modes_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .core_txd, .tx_empty, .tx_busy_char, .timeguard_run,
    .core_rxd, .tx_allow, .rx_enable_ok, .rxd_pin, .txd_pin, .rts_n_pin, .dtr_n_pin,
    .modem_n_pin);
  line_partner line_partner_i (.pclk, .rxd_pin, .modem_n_pin);

  always #25 pclk = ~pclk;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // pins {rx ok, tx allow, dtr, rts, core rxd, txd} per channel mode
  function automatic logic [32:0] exp_chan(input int c, input logic t);
    logic [5:0] p;
    p = {1'b1, 3'b000, ~t, t};
    if (c == 1) p[0] = ~t;
    if (c == 2) p[1:0] = {t, 1'b1};
    if (c == 3) p = {1'b0, 4'b0000, ~t};
    return {27'h0, p};
  endfunction : exp_chan

  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt

  // one apb transfer, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rd(input string nm, input logic [7:0] a, input logic [32:0] m, e);
    notes.push_back('{nm, 0, m, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // kind 1 pins, 2 receiver low count, 3 transmit active cycle count
  task automatic pin(input string nm, input int k, input logic [32:0] m, e);
    notes.push_back('{nm, k, m, e});
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 0;
    @(posedge pclk);
  endtask : pin

  // ---------------------------------------------------------------
  // watcher: counts receive low and transmit active cycles, compares the oldest note
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    if (clr) begin
      rx_lo = 0;
      tx_act = 0;
      txd_idle = txd_pin;
    end else begin
      if (core_rxd === 1'b0) rx_lo++;
      if (txd_pin !== txd_idle) tx_act++;
    end
    if (notes.size() > 0 && (probe || (psel && penable && pready && !pwrite))) begin
      nt = notes.pop_front();
      case (nt.kind)
        0: got = {pslverr, prdata};
        1: got = {27'h0, rx_enable_ok, tx_allow, dtr_n_pin, rts_n_pin, core_rxd, txd_pin};
        2: got = 33'(rx_lo);
        default: got = 33'(tx_act);
      endcase
      `CHK(nt.nm, nt.exp, got & nt.msk)
    end
  end

  // hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    wt(4);
    presetn <= 1'b1;
    @(posedge pclk);
    rnd = xs(rnd);
    f = 4 + int'(rnd[2:0]);
    pin("dtr reset", 1, 33'h08, 33'h08);
    rd("ratio", CARD_CLOCK_RATIO_OFF, 33'h1_0000_ffff, {17'h0, CLOCK_RATIO_RST});
    rd("mode", MODE_REG_OFF, '1, {1'b0, MODE_RST});
    rd("divisor", BAUD_DIVISOR_OFF, 33'h1_0000_ffff, {17'h0, DIVISOR_RST});
    rd("timeguard", TIMEGUARD_REG_OFF, 33'h1_0000_00ff, {25'h0, TIMEGUARD_RST});
    apb(1'b1, 8'h30, rnd);
    rd("unmapped", 8'h30, '1, 33'h1_0000_0000);
    apb(1'b1, CARD_CLOCK_RATIO_OFF, 32'h0000_0010);
    apb(1'b1, IR_FILTER_REG_OFF, 32'(f));
    rd("filter", IR_FILTER_REG_OFF, 33'h1_0000_00ff, 33'(f));
    // channel test modes, both line levels
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, MODE_REG_OFF, 32'(c) << CHAN_MODE_LSB);
      for (int v = 0; v < 2; v++) begin
        core_txd <= v[0];
        line_partner_i.set_line(~v[0]);
        wt(4);
        pin("chan", 1, c == 3 ? 33'h31 : 33'h23, exp_chan(c, v[0]));
      end
    end
    core_txd <= 1'b1;
    line_partner_i.set_line(1'b1);
    // line driver enable over empty and timeguard
    apb(1'b1, MODE_REG_OFF, {28'h0, OP_RS485});
    for (int k = 0; k < 4; k++) begin
      tx_empty <= k[0];
      timeguard_run <= k[1];
      wt(2);
      pin("rs485 rts", 1, 33'h04, k == 1 ? 33'h00 : 33'h04);
    end
    timeguard_run <= 1'b0;
    apb(1'b1, MODE_REG_OFF, {28'h0, OP_MODEM});
    for (int k = 0; k < 2; k++) begin
      tx_empty <= k[0];
      wt(2);
      pin("modem rts", 1, 33'h04, {30'h0, k[0], 2'b00});
    end
    apb(1'b1, CONTROL_REG_OFF, 32'h0001_0000);
    pin("ready on", 1, 33'h08, 33'h00);
    apb(1'b1, CONTROL_REG_OFF, 32'h0003_0000);
    pin("ready both", 1, 33'h08, 33'h08);
    apb(1'b1, CONTROL_REG_OFF, 32'h0001_0000);
    apb(1'b1, CONTROL_REG_OFF, 32'h0002_0000);
    pin("ready off", 1, 33'h08, 33'h08);
    rd("status", CHANNEL_STATUS_OFF, 33'h0, 33'h0);
    // each modem input changes once, flag then cleared by the read
    for (int i = 0; i < 4; i++) begin
      line_partner_i.set_modem(modem_n_pin ^ (4'b1000 >> i));
      wt(4);
      rd("flag", CHANNEL_STATUS_OFF, 33'h0_000f_0200,
         33'(32'h0000_0200 | (32'h0001_0000 << i)));
      rd("flag clear", CHANNEL_STATUS_OFF, 33'h0_000f_0000, 33'h0);
    end
    pin("cts off", 1, 33'h10, 33'h00);
    tx_busy_char <= 1'b1;
    pin("cts busy", 1, 33'h10, 33'h10);
    tx_busy_char <= 1'b0;
    line_partner_i.set_modem(4'h0);
    wt(4);
    pin("cts on", 1, 33'h10, 33'h10);
    // infrared codec with a short sample tick
    d = 1;
    apb(1'b1, BAUD_DIVISOR_OFF, 32'(d));
    apb(1'b1, MODE_REG_OFF, {28'h0, OP_IRDA});
    wt(40);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    line_partner_i.ir_pulse(f - 2);
    wt(60);
    pin("short pulse", 2, '1, 33'h0);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    line_partner_i.ir_pulse(f + 4);
    wt(80);
    pin("long pulse", 2, '1, 33'(16 * (d + 1)));
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    wt(64);
    pin("one bits", 3, '1, 33'h0);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    core_txd <= 1'b0;
    wt(32);
    core_txd <= 1'b1;
    wt(40);
    pin("zero bit", 3, '1, 33'(PULSE_SAMPLES * (d + 1)));
    print_verdict();
  end
endmodule : testbench
